// [hdl/pfs_pin_function_select.sv]
// Pin function select: per-pin function registers for ports B..G and
// the timer and alternate serial input-source selectors.
// Assumes pins and peripheral signals are synchronous to clk_sys.
//
// Functional notes
// - PB3 field: 00 gpio, 01 column 40, 10 alt data in, 11 data out.
// - PB2 field: 00 gpio, 01 column 41, 10 chip select, 11 alt clock.
// - PB1 field: 00 gpio/external_interrupt_one, 01 column 42, 10 inverted std timer, 11 ovp.
// - PB0 field: 00 gpio, 01 column 43, 10 shared serial clock, 11 ovp.
// - PB7 field: gpio for 00/01/10, bias gate for 11.
// - Unimplemented register bits ignore writes and read zero.
// - PC3 field: gpio plus timer2 clock for 00/01/10, adc input 1 for 11.
// - PC2 field: 00 gpio/t2 capture, 01 t2 out, 10 vref, 11 adc 0.
// - PC1 field: gpio plus timer1 clock for 00/01/10, adc input 3 for 11.
// - PC0 field: 00/01 gpio/t1 capture, 10 t1 out, 11 adc 2.
// - PC5 field: 00/01 gpio, 10 uart1 transmit, 11 alt data out.
// - PC4 field: 00/01 gpio, 10 uart1 receive, 11 alt chip select.
// - PD0..3: 00/01 gpio, 10 columns 0..3, 11 backplanes 4..7.
// - PD4..7: gpio for 00/01/10, columns 36..39 for 11.
// - PE0..7: gpio for 00/01/10, columns 28..35 for 11.
// - PF0..7: gpio for 00/01/10, columns 20..27 for 11.
// - PG0..2: 00/01 gpio, 10 pump nodes, 11 columns 45..47.
// - Source bits pick timer 1/2 captures and timer2/standard timer clock inputs between two pins.
// - Timer0 capture from PA0, or internal overvoltage irq when set.
// - Alt serial select, data in and clock each pick between two pins.
module pfs_pin_function_select
   import pfs_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire pfs_bus_req_type   bus_req,
   output      logic [7:0]        rdata,
   // Port input pin levels (bit n of each port)
   input  wire logic [7:0]        pin_a_in,
   input  wire logic [7:0]        pin_b_in,
   input  wire logic [7:0]        pin_c_in,
   // Port output pin drive and enable from the gpio logic
   input  wire logic [7:0]        gpio_b_out,
   input  wire logic [7:0]        gpio_b_oe,
   input  wire logic [7:0]        gpio_c_out,
   input  wire logic [7:0]        gpio_c_oe,
   // Peripheral outputs that may reach a pin, plus the overvoltage irq for timer0 capture
   input  wire logic              standard_timer_out_inverted,
   input  wire logic              serial_data_out,
   input  wire logic              serial_chip_select,
   input  wire logic              serial_alt_clock_out,
   input  wire logic              serial_clock_shared,
   input  wire logic              serial_alt_data_out,
   input  wire logic              periodic_timer1_out,
   input  wire logic              periodic_timer2_out,
   input  wire logic              uart_one_transmit,
   input  wire logic              overvoltage_irq,
   // Final pin drive for ports B and C
   output      logic [7:0]        pin_b_out,
   output      logic [7:0]        pin_b_oe,
   output      logic [7:0]        pin_c_out,
   output      logic [7:0]        pin_c_oe,
   // Peripheral inputs: periph_in after source selection, the other three straight from their pins
   output      pfs_periph_in_type periph_in,
   output      logic              external_interrupt_one,
   output      logic              periodic_timer1_clock_in,
   output      logic              uart_one_receive,
   // Analog and LCD enables, one bit per function
   output      logic [3:0]        adc_input_en,
   output      logic              adc_vref_en,
   output      logic [3:0]        lcd_column_low_en,
   output      logic [3:0]        lcd_backplane_en,
   output      logic [19:0]       lcd_column_mid_en,
   output      logic [7:0]        lcd_column_high_en,
   output      logic              lcd_bias_gate,
   output      logic [2:0]        pump_node_en,
   output      logic [1:0]        overvoltage_input_en
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] sel_q [PFS_NUM_REGS];
   logic [7:0] rdata_q;

   // Which bits each register really implements
   localparam logic [7:0] REG_MASK [PFS_NUM_REGS] = '{PFS_MASK_FULL,
      PFS_MASK_PB_HI, PFS_MASK_FULL, PFS_MASK_PC_HI, PFS_MASK_FULL,
      PFS_MASK_FULL, PFS_MASK_FULL, PFS_MASK_FULL, PFS_MASK_FULL,
      PFS_MASK_FULL, PFS_MASK_PG, PFS_MASK_TMR_IN, PFS_MASK_SER_IN};

   // Address decode: anything past the last register is unmapped
   wire addr_hit = int'(bus_req.addr) < PFS_NUM_REGS;

   // Masked write per register; masking at write keeps the flops of
   // unimplemented bits at zero so they need no read-side gating
   genvar gi;
   generate
      for (gi = 0; gi < PFS_NUM_REGS; gi++) begin : g_reg
         wire wr_hit = bus_req.wr && (int'(bus_req.addr) == gi);
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               sel_q[gi] <= PFS_RESET_VAL;
            end else if (wr_hit) begin
               sel_q[gi] <= bus_req.wdata & REG_MASK[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read port: data stands one cycle after the strobe, zero otherwise
   // ----------------------------------------------------------------
   wire [7:0] rd_sel = addr_hit ? sel_q[bus_req.addr] : PFS_READ_UNMAP;

   always_ff @(posedge clk_sys) begin
      rdata_q <= (bus_req.rd && !reset) ? rd_sel : PFS_READ_UNMAP;
   end
   assign rdata = rdata_q;

   // ----------------------------------------------------------------
   // Field slicing
   // ----------------------------------------------------------------
   wire [1:0] f_pb3 = sel_q[0][7:6];
   wire [1:0] f_pb2 = sel_q[0][5:4];
   wire [1:0] f_pb1 = sel_q[0][3:2];
   wire [1:0] f_pb0 = sel_q[0][1:0];
   wire [1:0] f_pb7 = sel_q[1][7:6];
   wire [1:0] f_pc3 = sel_q[2][7:6];
   wire [1:0] f_pc2 = sel_q[2][5:4];
   wire [1:0] f_pc1 = sel_q[2][3:2];
   wire [1:0] f_pc0 = sel_q[2][1:0];
   wire [1:0] f_pc5 = sel_q[3][3:2];
   wire [1:0] f_pc4 = sel_q[3][1:0];
   wire [7:0] src_t = sel_q[11];
   wire [7:0] src_s = sel_q[12];

   // ----------------------------------------------------------------
   // Port B output mux; gpio keeps PB0..PB3 only at code 00, PB7 at any code but 11
   // ----------------------------------------------------------------
   wire pb3_lcd = f_pb3 == PFS_CODE_1;
   wire pb3_sdo = f_pb3 == PFS_CODE_3;
   wire pb2_lcd = f_pb2 == PFS_CODE_1;
   wire pb2_cs  = f_pb2 == PFS_CODE_2;
   wire pb2_ck  = f_pb2 == PFS_CODE_3;
   wire pb1_lcd = f_pb1 == PFS_CODE_1;
   wire pb1_stb = f_pb1 == PFS_CODE_2;
   wire pb1_ovp = f_pb1 == PFS_CODE_3;
   wire pb0_lcd = f_pb0 == PFS_CODE_1;
   wire pb0_sck = f_pb0 == PFS_CODE_2;
   wire pb0_ovp = f_pb0 == PFS_CODE_3;
   wire pb7_vg  = f_pb7 == PFS_CODE_3;

   // Pins given to analog, lcd or an input function float digitally
   wire [7:0] b_gpio = {~pb7_vg, 3'b111,
                        f_pb3 == PFS_CODE_0, f_pb2 == PFS_CODE_0,
                        f_pb1 == PFS_CODE_0, f_pb0 == PFS_CODE_0};
   wire [7:0] b_per_oe = {4'h0, pb3_sdo, pb2_cs | pb2_ck, pb1_stb,
                          pb0_sck};
   wire [7:0] b_per_out = {4'h0, serial_data_out,
      pb2_cs ? serial_chip_select : serial_alt_clock_out,
      standard_timer_out_inverted, serial_clock_shared};

   assign pin_b_out = (b_gpio & gpio_b_out) | (b_per_oe & b_per_out);
   assign pin_b_oe  = (b_gpio & gpio_b_oe) | b_per_oe;

   // ----------------------------------------------------------------
   // Port C output mux
   // ----------------------------------------------------------------
   wire pc2_t2o = f_pc2 == PFS_CODE_1;
   wire pc0_t1o = f_pc0 == PFS_CODE_2;
   wire pc5_tx  = f_pc5 == PFS_CODE_2;
   wire pc5_sdo = f_pc5 == PFS_CODE_3;
   wire pc4_rx  = f_pc4 == PFS_CODE_2;

   wire [7:0] c_gpio = {2'b11,
                        f_pc5 <= PFS_CODE_1, f_pc4 <= PFS_CODE_1,
                        f_pc3 != PFS_CODE_3, f_pc2 == PFS_CODE_0,
                        f_pc1 != PFS_CODE_3, f_pc0 <= PFS_CODE_1};
   wire [7:0] c_per_oe = {2'b00, pc5_tx | pc5_sdo, 1'b0, 1'b0,
                          pc2_t2o, 1'b0, pc0_t1o};
   wire [7:0] c_per_out = {2'b00,
      pc5_tx ? uart_one_transmit : serial_alt_data_out,
      2'b00, periodic_timer2_out, 1'b0, periodic_timer1_out};

   assign pin_c_out = (c_gpio & gpio_c_out) | (c_per_oe & c_per_out);
   assign pin_c_oe  = (c_gpio & gpio_c_oe) | c_per_oe;

   // ----------------------------------------------------------------
   // Analog, reference and overvoltage enables
   // ----------------------------------------------------------------
   assign adc_input_en = {f_pc1 == PFS_CODE_3,
                          f_pc0 == PFS_CODE_3,
                          f_pc3 == PFS_CODE_3,
                          f_pc2 == PFS_CODE_3};
   assign adc_vref_en = f_pc2 == PFS_CODE_2;
   assign overvoltage_input_en = {pb1_ovp, pb0_ovp};
   assign lcd_bias_gate = pb7_vg;

   // ----------------------------------------------------------------
   // LCD column and backplane enables, port B by plain assigns, ports D..G by generate loops
   // ----------------------------------------------------------------
   // Bits 19:16 = columns 40..43 (PB3..PB0), bits 15:0 = columns 20..35
   assign lcd_column_mid_en[19] = pb3_lcd;
   assign lcd_column_mid_en[18] = pb2_lcd;
   assign lcd_column_mid_en[17] = pb1_lcd;
   assign lcd_column_mid_en[16] = pb0_lcd;

   generate
      for (gi = 0; gi < 8; gi++) begin : g_lcd8
         // Port F 0..7 -> columns 20..27, port E 0..7 -> 28..35
         assign lcd_column_mid_en[gi] =
            sel_q[8 + gi / 4][2*(gi%4) +: 2] == PFS_CODE_3;
         assign lcd_column_mid_en[8 + gi] =
            sel_q[6 + gi / 4][2*(gi%4) +: 2] == PFS_CODE_3;
      end
      for (gi = 0; gi < 4; gi++) begin : g_lcd4
         wire [1:0] fd_lo = sel_q[4][2*gi +: 2];
         wire [1:0] fd_hi = sel_q[5][2*gi +: 2];
         assign lcd_column_low_en[gi] = fd_lo == PFS_CODE_2;
         assign lcd_backplane_en[gi]  = fd_lo == PFS_CODE_3;
         // Bits 3:0 = columns 36..39, bits 7:4 = columns 44..47
         assign lcd_column_high_en[gi] = fd_hi == PFS_CODE_3;
      end
      for (gi = 0; gi < 3; gi++) begin : g_pg
         wire [1:0] fg = sel_q[10][2*gi +: 2];
         assign pump_node_en[gi] = fg == PFS_CODE_2;
         assign lcd_column_high_en[5 + gi] = fg == PFS_CODE_3;
      end
   endgenerate
   // Column 44 sits on a port A pin, outside this block
   assign lcd_column_high_en[4] = 1'b0;

   // ----------------------------------------------------------------
   // Input source selection; the chosen pin is sampled whatever its
   // output field says, so software must keep the two consistent
   // ----------------------------------------------------------------
   assign periph_in.t2_cap  = src_t[PFS_BIT_T2_CAP] ? pin_c_in[2]
      : pin_a_in[4];
   assign periph_in.t1_cap  = src_t[PFS_BIT_T1_CAP] ? pin_c_in[0]
      : pin_a_in[3];
   assign periph_in.t0_cap  = src_t[PFS_BIT_T0_CAP] ? overvoltage_irq
      : pin_a_in[0];
   assign periph_in.t2_clk  = src_t[PFS_BIT_T2_CLK] ? pin_a_in[7]
      : pin_c_in[3];
   assign periph_in.std_clk = src_t[PFS_BIT_STD_CLK] ? pin_a_in[6]
      : pin_a_in[1];
   assign periph_in.alt_cs  = src_s[PFS_BIT_ALT_CS] ? pin_c_in[4]
      : pin_a_in[4];
   assign periph_in.alt_di  = src_s[PFS_BIT_ALT_DI] ? pin_b_in[3]
      : pin_a_in[6];
   assign periph_in.alt_ck  = src_s[PFS_BIT_ALT_CK] ? pin_b_in[2]
      : pin_a_in[5];

   // Inputs that share a pin with gpio follow the pin level directly
   assign external_interrupt_one   = pin_b_in[1];
   assign periodic_timer1_clock_in = pin_c_in[1];
   assign uart_one_receive         = pin_c_in[4];

endmodule

// [hdl/pfs_pkg.sv]
// Pin function select package: register map, masks, codes, structs.
// Assumes an 8-bit CPU register port and one system clock.
package pfs_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte-wide registers on the plain port)
   // ----------------------------------------------------------------
   localparam logic [3:0] PFS_ADDR_PB_LO  = 4'h0;
   localparam logic [3:0] PFS_ADDR_PB_HI  = 4'h1;
   localparam logic [3:0] PFS_ADDR_PC_LO  = 4'h2;
   localparam logic [3:0] PFS_ADDR_PC_HI  = 4'h3;
   localparam logic [3:0] PFS_ADDR_PD_LO  = 4'h4;
   localparam logic [3:0] PFS_ADDR_PD_HI  = 4'h5;
   localparam logic [3:0] PFS_ADDR_PE_LO  = 4'h6;
   localparam logic [3:0] PFS_ADDR_PE_HI  = 4'h7;
   localparam logic [3:0] PFS_ADDR_PF_LO  = 4'h8;
   localparam logic [3:0] PFS_ADDR_PF_HI  = 4'h9;
   localparam logic [3:0] PFS_ADDR_PG     = 4'ha;
   localparam logic [3:0] PFS_ADDR_TMR_IN = 4'hb;
   localparam logic [3:0] PFS_ADDR_SER_IN = 4'hc;
   localparam int         PFS_NUM_REGS    = 13;

   // ----------------------------------------------------------------
   // Implemented-bit masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PFS_MASK_FULL   = 8'hff;
   localparam logic [7:0] PFS_MASK_PB_HI  = 8'hc0;
   localparam logic [7:0] PFS_MASK_PC_HI  = 8'h0f;
   localparam logic [7:0] PFS_MASK_PG     = 8'h3f;
   localparam logic [7:0] PFS_MASK_TMR_IN = 8'he9;
   localparam logic [7:0] PFS_MASK_SER_IN = 8'h70;
   localparam logic [7:0] PFS_RESET_VAL   = 8'h00;
   localparam logic [7:0] PFS_READ_UNMAP  = 8'h00;

   // Input source bit positions
   localparam int PFS_BIT_T2_CAP  = 7;
   localparam int PFS_BIT_T1_CAP  = 6;
   localparam int PFS_BIT_T0_CAP  = 5;
   localparam int PFS_BIT_T2_CLK  = 3;
   localparam int PFS_BIT_STD_CLK = 0;
   localparam int PFS_BIT_ALT_CS  = 6;
   localparam int PFS_BIT_ALT_DI  = 5;
   localparam int PFS_BIT_ALT_CK  = 4;

   // Two-bit function codes
   localparam logic [1:0] PFS_CODE_0 = 2'h0;
   localparam logic [1:0] PFS_CODE_1 = 2'h1;
   localparam logic [1:0] PFS_CODE_2 = 2'h2;
   localparam logic [1:0] PFS_CODE_3 = 2'h3;

   // ----------------------------------------------------------------
   // Carrier structs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pfs_bus_req_type;

   // Peripheral-facing input selections (one bit per pin-level input)
   typedef struct packed {
      logic t2_cap;
      logic t1_cap;
      logic t0_cap;
      logic t2_clk;
      logic std_clk;
      logic alt_cs;
      logic alt_di;
      logic alt_ck;
   } pfs_periph_in_type;

endpackage

// [tb/pfs_board_model.sv]
// Board model: undriven pads at board level, peripherals toggling.
// Assumes the bench gates the peripherals around each reselection.
module pfs_board_model
#(
   parameter logic [7:0] A_IDLE = 8'h3b,
   parameter logic [7:0] B_IDLE = 8'h08,
   parameter logic [7:0] C_IDLE = 8'h08
)
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       periph_en,
   input  wire logic [7:0] pin_b_out,
   input  wire logic [7:0] pin_b_oe,
   input  wire logic [7:0] pin_c_out,
   input  wire logic [7:0] pin_c_oe,
   output      logic [7:0] pin_a_in,
   output      logic [7:0] pin_b_in,
   output      logic [7:0] pin_c_in,
   output      logic [9:0] periph_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tgl_q;

   // An undriven pad settles to its board level, not to the last drive
   assign pin_a_in = A_IDLE;
   assign pin_b_in = (pin_b_oe & pin_b_out) | (~pin_b_oe & B_IDLE);
   assign pin_c_in = (pin_c_oe & pin_c_out) | (~pin_c_oe & C_IDLE);
   // Disabled peripherals hold low so a reselection never glitches
   assign periph_out = periph_en ? {5{tgl_q, ~tgl_q}} : 10'h000;

   // Toggle so a stale pin value cannot pass for a live one
   always_ff @(posedge clk_sys) begin
      tgl_q <= reset ? 1'b0 : ~tgl_q;
   end
endmodule

// [tb/pfs_select_props.sv]
// Checker: register shadow plus decode, source and drive relations.
// Assumes it is bound to the top module and sees only its ports.
module pfs_select_props
   import pfs_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              reset,
   input wire pfs_bus_req_type   bus_req,
   input wire logic [7:0]        rdata,
   input wire logic [7:0]        pin_a_in,
   input wire logic [7:0]        pin_b_in,
   input wire logic [7:0]        pin_c_in,
   input wire logic [7:0]        gpio_b_out,
   input wire logic [7:0]        gpio_b_oe,
   input wire logic              serial_data_out,
   input wire logic              overvoltage_irq,
   input wire logic [7:0]        pin_b_out,
   input wire logic [7:0]        pin_b_oe,
   input wire pfs_periph_in_type periph_in,
   input wire logic [3:0]        adc_input_en,
   input wire logic [3:0]        lcd_backplane_en,
   input wire logic [19:0]       lcd_column_mid_en,
   input wire logic [7:0]        lcd_column_high_en,
   input wire logic              lcd_bias_gate,
   input wire logic [2:0]        pump_node_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // -----------------------------------------------------------------
   // Register shadow
   // -----------------------------------------------------------------
   function automatic logic [3:0] code4(input logic [7:0] r,
                                        input logic [1:0] c);
      for (int i = 0; i < 4; i++) begin
         code4[i] = (r[2*i +: 2] == c);
      end
   endfunction

   logic [7:0] sh_q [PFS_NUM_REGS];
   // Write mask per index; unimplemented bits never reach the shadow
   wire [7:0] wmask =
      (bus_req.addr == PFS_ADDR_PB_HI)  ? PFS_MASK_PB_HI  :
      (bus_req.addr == PFS_ADDR_PC_HI)  ? PFS_MASK_PC_HI  :
      (bus_req.addr == PFS_ADDR_PG)     ? PFS_MASK_PG     :
      (bus_req.addr == PFS_ADDR_TMR_IN) ? PFS_MASK_TMR_IN :
      (bus_req.addr == PFS_ADDR_SER_IN) ? PFS_MASK_SER_IN : PFS_MASK_FULL;
   wire [7:0] rd_view = (bus_req.addr < 4'hd) ? sh_q[bus_req.addr] : 8'h00;
   wire [7:0] tmr = sh_q[PFS_ADDR_TMR_IN];
   wire [7:0] ser = sh_q[PFS_ADDR_SER_IN];
   wire [3:0] pg_c3 = code4(sh_q[PFS_ADDR_PG], 2'h3);
   wire [3:0] pg_c2 = code4(sh_q[PFS_ADDR_PG], 2'h2);
   wire [3:0] pc_c3 = code4(sh_q[PFS_ADDR_PC_LO], 2'h3);

   // Shadow follows accepted writes only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sh_q <= '{default: 8'h00};
      end else if (bus_req.wr && bus_req.addr < 4'hd) begin
         sh_q[bus_req.addr] <= bus_req.wdata & wmask;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   rdata_idle_a: assert property (
      !bus_req.rd |=> rdata == 8'h00) else $error("rdata not idle");
   read_back_a: assert property (
      bus_req.rd |=> rdata == $past(rd_view)) else $error("bad read data");
   reset_clear_a: assert property (
      $fell(reset) |-> adc_input_en == 4'h0 && lcd_column_mid_en == 20'h0
         && !lcd_bias_gate && pump_node_en == 3'h0 && periph_in.t0_cap
         == pin_a_in[0]) else $error("select not clear after reset");
   bias_gate_a: assert property (
      lcd_bias_gate == (sh_q[PFS_ADDR_PB_HI][7:6] == 2'h3))
      else $error("bias gate decode wrong");
   adc_decode_a: assert property (
      adc_input_en == {pc_c3[1], pc_c3[0], pc_c3[3], pc_c3[2]})
      else $error("analog input decode wrong");
   lcd_column_a: assert property (
      lcd_column_mid_en == {code4(sh_q[PFS_ADDR_PB_LO], 2'h1),
         code4(sh_q[PFS_ADDR_PE_HI], 2'h3), code4(sh_q[PFS_ADDR_PE_LO], 2'h3),
         code4(sh_q[PFS_ADDR_PF_HI], 2'h3), code4(sh_q[PFS_ADDR_PF_LO], 2'h3)}
      && lcd_column_high_en == {pg_c3[2:0], 1'b0,
         code4(sh_q[PFS_ADDR_PD_HI], 2'h3)}) else $error("column decode");
   pump_plane_a: assert property (
      pump_node_en == pg_c2[2:0] && lcd_backplane_en ==
      code4(sh_q[PFS_ADDR_PD_LO], 2'h3)) else $error("pump or plane decode");
   timer_source_a: assert property (
      periph_in.t2_cap == (tmr[7] ? pin_c_in[2] : pin_a_in[4]) &&
      periph_in.t1_cap == (tmr[6] ? pin_c_in[0] : pin_a_in[3]) &&
      periph_in.t2_clk == (tmr[3] ? pin_a_in[7] : pin_c_in[3]) &&
      periph_in.std_clk == (tmr[0] ? pin_a_in[6] : pin_a_in[1]))
      else $error("timer source wrong");
   t0_source_a: assert property (
      periph_in.t0_cap == (tmr[5] ? overvoltage_irq : pin_a_in[0]))
      else $error("timer0 capture source wrong");
   alt_source_a: assert property (
      periph_in.alt_cs == (ser[6] ? pin_c_in[4] : pin_a_in[4]) &&
      periph_in.alt_di == (ser[5] ? pin_b_in[3] : pin_a_in[6]) &&
      periph_in.alt_ck == (ser[4] ? pin_b_in[2] : pin_a_in[5]))
      else $error("serial source wrong");
   pb3_drive_a: assert property (
      sh_q[PFS_ADDR_PB_LO][7:6] == 2'h3 |-> pin_b_oe[3] &&
      pin_b_out[3] == serial_data_out) else $error("data out not on pin");
   pb3_gpio_a: assert property (
      sh_q[PFS_ADDR_PB_LO][7:6] == 2'h0 |-> pin_b_oe[3] == gpio_b_oe[3] &&
      (!gpio_b_oe[3] || pin_b_out[3] == gpio_b_out[3]))
      else $error("gpio drive lost");

   cover property (bus_req.rd && bus_req.addr == PFS_ADDR_SER_IN);
   cover property ($fell(reset));
   cover property (lcd_bias_gate && pump_node_en == 3'h7);
endmodule

bind pfs_pin_function_select pfs_select_props pfs_select_props_i (
   .clk_sys, .reset, .bus_req, .rdata, .pin_a_in, .pin_b_in, .pin_c_in,
   .gpio_b_out, .gpio_b_oe, .serial_data_out, .overvoltage_irq, .pin_b_out,
   .pin_b_oe, .periph_in, .adc_input_en, .lcd_backplane_en,
   .lcd_column_mid_en, .lcd_column_high_en, .lcd_bias_gate, .pump_node_en);

// [tb/pin_function_select_test.sv]
// Bench for the pin function select block: register table, every code,
// mid-run reset and source selectors. Needs the board model.
module pin_function_select_test import pfs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PA = 8'h3b;
   localparam logic [7:0] PB = 8'h08;
   localparam logic [7:0] PC = 8'h08;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } pfs_row_type;
   // Address, write data, expected read back (masked, or 0 if unmapped)
   pfs_row_type rows [15] = '{
      '{4'h0, 8'hc7, 8'hc7}, '{4'h1, 8'hff, 8'hc0}, '{4'h2, 8'h9b, 8'h9b},
      '{4'h3, 8'hff, 8'h0f}, '{4'h4, 8'he4, 8'he4}, '{4'h5, 8'h5a, 8'h5a},
      '{4'h6, 8'haa, 8'haa}, '{4'h7, 8'h55, 8'h55}, '{4'h8, 8'h3c, 8'h3c},
      '{4'h9, 8'hc3, 8'hc3}, '{4'ha, 8'hff, 8'h3f}, '{4'hb, 8'hff, 8'he9},
      '{4'hc, 8'hff, 8'h70}, '{4'hd, 8'hff, 8'h00}, '{4'hf, 8'h12, 8'h00}};
   logic clk_sys, reset, periph_en, lcd_bias_gate, adc_vref_en;
   logic external_interrupt_one, periodic_timer1_clock_in, uart_one_receive;
   pfs_bus_req_type   bus_req;
   pfs_periph_in_type periph_in;
   logic [7:0] rdata, pin_a_in, pin_b_in, pin_c_in, d, exp;
   logic [7:0] gpio_b_out, gpio_b_oe, gpio_c_out, gpio_c_oe;
   logic [7:0] pin_b_out, pin_b_oe, pin_c_out, pin_c_oe, lcd_column_high_en;
   logic [9:0] periph_out;
   logic [3:0] adc_input_en, lcd_column_low_en, lcd_backplane_en;
   logic [19:0] lcd_column_mid_en;
   logic [2:0] pump_node_en;
   logic [1:0] overvoltage_input_en, code;
   int error_cnt = 0;
   int cmp_count = 0;

   pfs_pin_function_select pfs_pin_function_select_i (.clk_sys, .reset,
      .bus_req, .rdata, .pin_a_in, .pin_b_in, .pin_c_in, .gpio_b_out,
      .gpio_b_oe, .gpio_c_out, .gpio_c_oe,
      .standard_timer_out_inverted(periph_out[0]),
      .serial_data_out(periph_out[1]), .serial_chip_select(periph_out[2]),
      .serial_alt_clock_out(periph_out[3]),
      .serial_clock_shared(periph_out[4]),
      .serial_alt_data_out(periph_out[5]), .periodic_timer1_out(periph_out[6]),
      .periodic_timer2_out(periph_out[7]), .uart_one_transmit(periph_out[8]),
      .overvoltage_irq(periph_out[9]), .pin_b_out, .pin_b_oe, .pin_c_out,
      .pin_c_oe, .periph_in, .external_interrupt_one,
      .periodic_timer1_clock_in, .uart_one_receive, .adc_input_en,
      .adc_vref_en, .lcd_column_low_en, .lcd_backplane_en, .lcd_column_mid_en,
      .lcd_column_high_en, .lcd_bias_gate, .pump_node_en,
      .overvoltage_input_en);
   pfs_board_model #(.A_IDLE(PA), .B_IDLE(PB), .C_IDLE(PC)) pfs_board_model_i (
      .clk_sys, .reset, .periph_en, .pin_b_out, .pin_b_oe, .pin_c_out,
      .pin_c_oe, .pin_a_in, .pin_b_in, .pin_c_in, .periph_out);

   // -----------------------------------------------------------------
   // Bus tasks and checking
   // -----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      #1;
      v = rdata;
   endtask
   task automatic idle();
      bus_req <= '0;
      @(posedge clk_sys);
   endtask
   task automatic check(input string n, input logic [19:0] s, e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Whole run is about 120 cycles; this only cuts a hang short
   initial begin
      repeat (3000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      bus_req = '0;
      periph_en = 1'b0;
      {gpio_b_out, gpio_c_out} = 16'h0000;
      {gpio_b_oe, gpio_c_oe} = 16'hffff;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, d);
         check("read back", d, rows[i].e);
      end
      // Every code in every field; peripherals off while reselecting
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         periph_en <= 1'b0;
         for (int a = 0; a < 11; a++) begin
            wr(a[3:0], {4{code}});
         end
         idle();
         periph_en <= 1'b1;
         repeat (2) begin
            @(posedge clk_sys);
            #1;
            exp[0] = (code == 2'h0 || code == 2'h3);
            check("pb3 oe", pin_b_oe[3], exp[0]);
            check("pb3 out", pin_b_out[3] & exp[0], exp[0] & ((code == 2'h3)
               ? periph_out[1] : gpio_b_out[3]));
            check("pc5 out", {pin_c_oe[5], pin_c_out[5]}, {1'b1, (code == 2'h3)
               ? periph_out[5] : (code == 2'h2) ? periph_out[8]
               : gpio_c_out[5]});
         end
         check("adc", adc_input_en, {4{code == 2'h3}});
         check("vref", adc_vref_en, code == 2'h2);
         check("ovp", overvoltage_input_en, {2{code == 2'h3}});
         check("bias", lcd_bias_gate, code == 2'h3);
         check("col low", lcd_column_low_en, {4{code == 2'h2}});
         check("plane", lcd_backplane_en, {4{code == 2'h3}});
         check("col mid", lcd_column_mid_en, {{4{code == 2'h1}},
            {16{code == 2'h3}}});
         check("col high", lcd_column_high_en, {{3{code == 2'h3}}, 1'b0,
            {4{code == 2'h3}}});
         check("pump", pump_node_en, {3{code == 2'h2}});
      end
      // Second reset in mid-run clears every register
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int a = 0; a < 13; a++) begin
         rd(a[3:0], d);
         check("reset value", d, 8'h00);
      end
      gpio_b_oe <= 8'h00;
      gpio_c_oe <= 8'h00;
      for (int s = 0; s < 2; s++) begin
         wr(PFS_ADDR_TMR_IN, {8{s[0]}});
         wr(PFS_ADDR_SER_IN, {8{s[0]}});
         idle();
         #1;
         exp = s[0] ? {PC[2], PC[0], periph_out[9], PA[7], PA[6], PC[4],
            PB[3], PB[2]} : {PA[4], PA[3], PA[0], PC[3], PA[1], PA[4], PA[6],
            PA[5]};
         check("sources", periph_in, exp);
      end
      check("live", {external_interrupt_one, periodic_timer1_clock_in,
         uart_one_receive}, {PB[1], PC[1], PC[4]});
      finish_test();
   end
endmodule
